// ===== bbfo_ctrl.sv
/*
 * bbfo_ctrl: billboard failover sequencer with its register port.
 * assumes: pins are asynchronous; events are one-cycle pulses from the
 * internal function logic on clock_i; register reads answer one cycle later.
 */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bbfo_ctrl
    import bbfo_pkg::*;
#(
    parameter int TICK_CYC = BBFO_TICK_CYC
) (
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    // register port
    input  wire bbfo_req_t                req_i,
    output logic      [7:0]               rdata_o,
    // general-purpose pins, one per select code
    input  wire logic [BBFO_NUM_PINS-1:0] gpio_i,
    // events from the internal function
    input  wire bbfo_evt_t                evt_i,
    // controls to the internal function
    output bbfo_ctl_t                     ctl_o
);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] tmr_a;
        logic [15:0] tmr_b;
        logic [7:0]  rdata;
        bbfo_state_t st;
        logic [25:0] div;
        logic        tick;
        logic [7:0]  hold;
        logic        pin_prev;
        logic        pend;
    } bbfo_st_t;

    bbfo_st_t s_q;
    bbfo_st_t s_d;

    logic [BBFO_NUM_PINS-1:0] gpio_s;
    logic                     tmr_clr;
    logic                     a_run;
    logic                     b_run;
    logic                     a_exp;
    logic                     b_exp;
    logic [4:0]               sel;
    logic                     pin_lvl;
    logic                     fall;

    // all pins synchronised before use
    bbfo_sync #(.W(BBFO_NUM_PINS)) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (gpio_i),
        .sync_o  (gpio_s)
    );

    // reserved or out-of-range codes read as idle
    function automatic logic pick_pin(input logic [BBFO_NUM_PINS-1:0] p, input logic [4:0] c);
        if (c == BBFO_SEL_RSVD || c > BBFO_SEL_MAX) begin
            return 1'b1;
        end
        return p[c];
    endfunction : pick_pin

    assign sel     = s_q.ctrl[BBFO_CTRL_SEL_MSB:BBFO_CTRL_SEL_LSB];
    assign pin_lvl = pick_pin(gpio_s, sel);
    assign fall    = s_q.pin_prev && !pin_lvl;
    // timers only live while billboard is presented
    assign tmr_clr = (s_q.st != BBFO_ST_BB_WAIT) && (s_q.st != BBFO_ST_BB_RUN);

    bbfo_timer #(.W(16)) u_tmr_a (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (s_q.tick),
        .start_i   (evt_i.addr_set && s_q.st == BBFO_ST_BB_WAIT),
        .clear_i   (tmr_clr),
        .limit_i   (s_q.tmr_a),
        .running_o (a_run),
        .expire_o  (a_exp)
    );

    bbfo_timer #(.W(16)) u_tmr_b (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (s_q.tick),
        .start_i   (evt_i.alt_str_req && s_q.st == BBFO_ST_BB_RUN),
        .clear_i   (tmr_clr),
        .limit_i   (s_q.tmr_b),
        .running_o (b_run),
        .expire_o  (b_exp)
    );

    // register port, tick divider and sequencer
    always_comb begin
        s_d          = s_q;
        s_d.pin_prev = pin_lvl;
        s_d.rdata    = 8'h00;
        // 10 ms tick from the system clock
        if (s_q.div == 26'(TICK_CYC - 1)) begin
            s_d.div  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div  = s_q.div + 26'd1;
            s_d.tick = 1'b0;
        end
        if (req_i.wr) begin
            case (req_i.addr)
                BBFO_ADDR_CTRL:    s_d.ctrl = req_i.wdata & BBFO_CTRL_WMASK;
                BBFO_ADDR_TMRA_LO: s_d.tmr_a[7:0] = req_i.wdata;
                BBFO_ADDR_TMRA_HI: s_d.tmr_a[15:8] = req_i.wdata;
                BBFO_ADDR_TMRB_LO: s_d.tmr_b[7:0] = req_i.wdata;
                BBFO_ADDR_TMRB_HI: s_d.tmr_b[15:8] = req_i.wdata;
                default: ;
            endcase
        end
        if (req_i.rd) begin
            case (req_i.addr)
                BBFO_ADDR_CTRL:    s_d.rdata = s_q.ctrl;
                BBFO_ADDR_TMRA_LO: s_d.rdata = s_q.tmr_a[7:0];
                BBFO_ADDR_TMRA_HI: s_d.rdata = s_q.tmr_a[15:8];
                BBFO_ADDR_TMRB_LO: s_d.rdata = s_q.tmr_b[7:0];
                BBFO_ADDR_TMRB_HI: s_d.rdata = s_q.tmr_b[15:8];
                BBFO_ADDR_STATUS:  s_d.rdata = {3'b000, b_run, a_run, s_q.st};
                default:           s_d.rdata = 8'h00;
            endcase
        end
        if (s_q.tick && s_q.hold != 8'h00) begin
            s_d.hold = s_q.hold - 8'h01;
        end
        case (s_q.st)
            BBFO_ST_NORMAL: begin
                if (s_q.pend && s_q.ctrl[BBFO_CTRL_EN_BIT]) begin
                    s_d.pend = 1'b0;
                    s_d.hold = BBFO_DETACH_TICKS;
                    s_d.st   = BBFO_ST_DET_IN;
                end else if (!s_q.ctrl[BBFO_CTRL_EN_BIT]) begin
                    s_d.pend = 1'b0;
                end
            end
            BBFO_ST_DET_IN: begin
                if (s_q.hold == 8'h00) begin
                    s_d.st = BBFO_ST_BB_WAIT;
                end
            end
            BBFO_ST_BB_WAIT: begin
                if (a_run) begin
                    s_d.st = BBFO_ST_BB_RUN;
                end
            end
            BBFO_ST_BB_RUN: begin
                if (a_exp || b_exp) begin
                    s_d.hold = BBFO_DETACH_TICKS;
                    s_d.st   = BBFO_ST_DET_OUT;
                end
            end
            BBFO_ST_DET_OUT: begin
                if (s_q.hold == 8'h00) begin
                    s_d.st = BBFO_ST_NORMAL;
                end
            end
            default: s_d.st = BBFO_ST_NORMAL;
        endcase
        // edge latch after the sequencer: a new edge beats the consume
        if (fall && s_q.ctrl[BBFO_CTRL_EN_BIT]) begin
            s_d.pend = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q          <= '0;
            s_q.ctrl     <= BBFO_RST_CTRL;
            s_q.tmr_a    <= {BBFO_RST_TMRA_HI, BBFO_RST_TMRA_LO};
            s_q.tmr_b    <= {BBFO_RST_TMRB_HI, BBFO_RST_TMRB_LO};
            s_q.st       <= BBFO_ST_NORMAL;
            s_q.pin_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // register read data and outputs toward the internal function
    assign rdata_o              = s_q.rdata;
    assign ctl_o.detach         = (s_q.st == BBFO_ST_DET_IN) || (s_q.st == BBFO_ST_DET_OUT);
    assign ctl_o.billboard_mode = (s_q.st == BBFO_ST_BB_WAIT) || (s_q.st == BBFO_ST_BB_RUN)
                                  || (s_q.st == BBFO_ST_DET_IN);
    assign ctl_o.cfg_status     = BBFO_CFG_STATUS;
endmodule : bbfo_ctrl
`default_nettype wire

// ===== bbfo_pkg.sv
/*
 * bbfo_pkg: constants, states and carrier structs for the billboard failover control.
 * assumes: a single 50 MHz system clock domain; byte-wide register port.
 */
package bbfo_pkg;

    // register offsets (byte addresses on the plain register port)
    localparam logic [15:0] BBFO_ADDR_TMRA_LO = 16'h413c;
    localparam logic [15:0] BBFO_ADDR_TMRA_HI = 16'h413d;
    localparam logic [15:0] BBFO_ADDR_TMRB_LO = 16'h413e;
    localparam logic [15:0] BBFO_ADDR_TMRB_HI = 16'h413f;
    localparam logic [15:0] BBFO_ADDR_CTRL    = 16'h4140;
    localparam logic [15:0] BBFO_ADDR_STATUS  = 16'h4141;

    // reset values
    localparam logic [7:0]  BBFO_RST_TMRA_LO  = 8'hd0;
    localparam logic [7:0]  BBFO_RST_TMRA_HI  = 8'h07;
    localparam logic [7:0]  BBFO_RST_TMRB_LO  = 8'hd0;
    localparam logic [7:0]  BBFO_RST_TMRB_HI  = 8'h07;
    localparam logic [7:0]  BBFO_RST_CTRL     = 8'h14;

    // control field layout
    localparam int          BBFO_CTRL_EN_BIT  = 0;
    localparam int          BBFO_CTRL_SEL_LSB = 1;
    localparam int          BBFO_CTRL_SEL_MSB = 5;
    localparam logic [7:0]  BBFO_CTRL_WMASK   = 8'h3f;
    localparam logic [4:0]  BBFO_SEL_RSVD     = 5'h09;
    localparam logic [4:0]  BBFO_SEL_MAX      = 5'h10;
    localparam int          BBFO_NUM_PINS     = 17;

    // configured-status value reported by default (unspecified error)
    localparam logic [1:0]  BBFO_CFG_STATUS   = 2'h0;

    // tick timing: 10 ms per timer count at 50 MHz
    localparam int          BBFO_CLK_HZ       = 50_000_000;
    localparam int          BBFO_TICK_MS      = 10;
    localparam int          BBFO_TICK_CYC     = BBFO_CLK_HZ / 1000 * BBFO_TICK_MS;
    // forced detach hold time, in ticks
    localparam logic [7:0]  BBFO_DETACH_TICKS = 8'h0a;

    typedef enum logic [2:0] {
        BBFO_ST_NORMAL   = 3'b000,
        BBFO_ST_DET_IN   = 3'b001,
        BBFO_ST_BB_WAIT  = 3'b010,
        BBFO_ST_BB_RUN   = 3'b011,
        BBFO_ST_DET_OUT  = 3'b100
    } bbfo_state_t;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bbfo_req_t;

    // events from the internal function's device logic
    typedef struct packed {
        logic addr_set;
        logic alt_str_req;
    } bbfo_evt_t;

    // controls toward the internal function
    typedef struct packed {
        logic       detach;
        logic       billboard_mode;
        logic [1:0] cfg_status;
    } bbfo_ctl_t;

endpackage : bbfo_pkg

// ===== bbfo_sync.sv
/*
 * bbfo_sync: two-flop synchroniser for a bank of pin inputs.
 * assumes: inputs are asynchronous to clock_i; reset value is high (idle pins).
 */
`timescale 1ns/1ps
`default_nettype none
module bbfo_sync #(
    parameter int W = 17
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : bbfo_sync
`default_nettype wire

// ===== bbfo_timer.sv
/*
 * bbfo_timer: one 10 ms-granular detach timer with start, clear and expiry pulse.
 * assumes: tick_i is a one-cycle pulse every 10 ms from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bbfo_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // control
    input  wire logic         tick_i,
    input  wire logic         start_i,
    input  wire logic         clear_i,
    input  wire logic [W-1:0] limit_i,
    // status
    output logic              running_o,
    output logic              expire_o
);
    typedef struct packed {
        logic         run;
        logic [W-1:0] cnt;
        logic         exp;
    } bbfo_tmr_t;

    bbfo_tmr_t s_q;
    bbfo_tmr_t s_d;

    // counts ticks up to the limit; limit 0 expires on the first tick
    always_comb begin
        s_d     = s_q;
        s_d.exp = 1'b0;
        if (clear_i) begin
            s_d.run = 1'b0;
            s_d.cnt = '0;
        end else if (start_i && !s_q.run) begin
            s_d.run = 1'b1;
            s_d.cnt = '0;
        end else if (s_q.run && tick_i) begin
            if (s_q.cnt + W'(1) >= limit_i) begin
                s_d.run = 1'b0;
                s_d.exp = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign running_o = s_q.run;
    assign expire_o  = s_q.exp;
endmodule : bbfo_timer
`default_nettype wire

// ===== bbfo_ctrl_chk.sv
/* bbfo_ctrl_chk: port assertions for the failover sequencer.
   assumes: bound into bbfo_ctrl; one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module bbfo_ctrl_chk
    import bbfo_pkg::*;
#(
    parameter int TICK_CYC = 10
) (
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    // register port
    input  wire bbfo_req_t                req_i,
    input  wire logic [7:0]               rdata_o,
    // pins, events, controls
    input  wire logic [BBFO_NUM_PINS-1:0] gpio_i,
    input  wire bbfo_evt_t                evt_i,
    input  wire bbfo_ctl_t                ctl_o
);
    localparam int HOLD_MAX = TICK_CYC * 11 + 4;
    logic [7:0] ctrl_q;
    logic       arm_w;
    logic       pin_w;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the control register, fed by the same writes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            ctrl_q <= BBFO_RST_CTRL;
        else if (req_i.wr && req_i.addr == BBFO_ADDR_CTRL)
            ctrl_q <= req_i.wdata & BBFO_CTRL_WMASK;
    end
    // reserved code must not arm, its pin index is not a notice
    assign arm_w = ctrl_q[0] && ctrl_q[5:1] != BBFO_SEL_RSVD && ctrl_q[5:1] <= BBFO_SEL_MAX;
    assign pin_w = gpio_i[ctrl_q[5:1]];
    a_rdata_idle: assert property (
        !$past(req_i.rd) |-> rdata_o == 8'h00) else $error("read data outside read slot");
    a_ctrl_read: assert property (
        $past(req_i.rd) && $past(req_i.addr) == BBFO_ADDR_CTRL |-> rdata_o == $past(ctrl_q))
        else $error("control readback wrong");
    a_cfg_status: assert property (
        ctl_o.cfg_status == 2'b00) else $error("configured status not 00");
    a_attach_bb: assert property (
        $rose(ctl_o.billboard_mode) |-> ctl_o.detach) else $error("billboard without detach");
    a_exit_detach: assert property (
        $fell(ctl_o.billboard_mode) |-> ctl_o.detach) else $error("ordinary without detach");
    a_hold_min: assert property (
        $rose(ctl_o.detach) |-> ctl_o.detach [*8]) else $error("detach too short");
    a_hold_max: assert property (
        $rose(ctl_o.detach) |-> ##[1:HOLD_MAX] !ctl_o.detach) else $error("detach too long");
    a_enable_gate: assert property (
        $rose(ctl_o.detach) && ctl_o.billboard_mode |-> $past(ctrl_q[0], 2))
        else $error("sequence while disabled");
    a_notice_seen: assert property (
        arm_w && $stable(ctrl_q) && !ctl_o.detach && !ctl_o.billboard_mode && $fell(pin_w)
        |-> ##[2:8] ctl_o.detach && ctl_o.billboard_mode) else $error("notice not acted on");
    c_enter: cover property ($rose(ctl_o.billboard_mode));
    c_leave: cover property ($fell(ctl_o.billboard_mode));
    c_string: cover property (evt_i.alt_str_req && ctl_o.billboard_mode);
endmodule : bbfo_ctrl_chk
bind bbfo_ctrl bbfo_ctrl_chk #(.TICK_CYC(TICK_CYC)) u_chk (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .gpio_i(gpio_i),
    .evt_i(evt_i), .ctl_o(ctl_o));
`default_nettype wire

// ===== bbfo_far_model.sv
/* bbfo_far_model: notice pins of the delivery controller and host events.
   assumes: bench picks pin and moment; pins idle high by pull-up. */
`timescale 1ns/1ps
`default_nettype none
module bbfo_far_model
    import bbfo_pkg::*;
(
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    // bench commands
    input  wire logic [4:0]               pin_i,
    input  wire logic                     fail_i,
    input  wire logic                     alt_en_i,
    // block side
    input  wire bbfo_ctl_t                ctl_i,
    output logic      [BBFO_NUM_PINS-1:0] gpio_o,
    output bbfo_evt_t                     evt_o
);
    logic [7:0] cnt_q;
    // failure pulls the chosen pin low, the rest stay high
    always_comb begin
        gpio_o = '1;
        if (fail_i)
            gpio_o[pin_i] = 1'b0;
    end
    // host addresses the billboard function, later asks for the string
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            evt_o <= '0;
        end else begin
            cnt_q <= (ctl_i.billboard_mode && !ctl_i.detach && cnt_q != 8'hff) ? cnt_q + 8'h01
                : (ctl_i.billboard_mode && !ctl_i.detach) ? cnt_q : 8'h00;
            evt_o.addr_set <= cnt_q == 8'h05;
            evt_o.alt_str_req <= alt_en_i && cnt_q == 8'h09;
        end
    end
endmodule : bbfo_far_model
`default_nettype wire

// ===== test_billboard_failover_control.sv
/* test_billboard_failover_control: register and failover sequence tests.
   assumes: far model drives pins and host events; tick shortened to 10. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_billboard_failover_control
    import bbfo_pkg::*;
;
    localparam int T = 10;
    logic                     clock_i = 1'b0;
    logic                     rst_n_i = 1'b0;
    bbfo_req_t                req_i = '0;
    logic [7:0]               rdata_o;
    logic [BBFO_NUM_PINS-1:0] gpio_i;
    bbfo_evt_t                evt_i;
    bbfo_ctl_t                ctl_o;
    logic [4:0]               pin = 5'h0a;
    logic                     fail = 1'b0;
    logic                     alt_en = 1'b0;
    int                       num_errors = 0;
    int                       n_compared = 0;
    int                       k;
    initial forever #10 clock_i = ~clock_i;
    bbfo_ctrl #(.TICK_CYC(T)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i),
        .rdata_o(rdata_o), .gpio_i(gpio_i), .evt_i(evt_i), .ctl_o(ctl_o));
    bbfo_far_model far (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(pin), .fail_i(fail),
        .alt_en_i(alt_en), .ctl_i(ctl_o), .gpio_o(gpio_i), .evt_o(evt_i));
    task automatic test_done();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        req_i.wr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock_i);
        req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        req_i.rd <= 1'b0;
        @(negedge clock_i);
        `CHK(rdata_o, e)
    endtask : rd
    task automatic wait_det(input logic v, input int n, output int c);
        c = 0;
        while (ctl_o.detach !== v && c < n) begin
            @(negedge clock_i);
            c++;
        end
        `CHK(ctl_o.detach, v)
    endtask : wait_det
    // one round on pin s; expiry expected lo..hi cycles after the address
    task automatic round(input logic [4:0] s, input int lo, input int hi);
        int c;
        repeat (4) @(posedge clock_i);
        wr(BBFO_ADDR_CTRL, {2'b00, s, 1'b1});
        // let the select settle so the notice checker sees a stable control
        @(posedge clock_i);
        pin <= s;
        fail <= 1'b1;
        wait_det(1'b1, 8, c);
        `CHK(ctl_o.billboard_mode, 1'b1)
        `CHK(ctl_o.cfg_status, 2'b00)
        wait_det(1'b0, 12 * T, c);
        c = 0;
        while (!evt_i.addr_set && c < 20) begin
            @(negedge clock_i);
            c++;
        end
        wait_det(1'b1, 120 * T, c);
        `CHK(c >= lo && c <= hi, 1'b1)
        `CHK(ctl_o.billboard_mode, 1'b0)
        wait_det(1'b0, 12 * T, c);
        repeat (3 * T) @(negedge clock_i);
        `CHK(ctl_o.detach, 1'b0)
        @(posedge clock_i);
        fail <= 1'b0;
    endtask : round
    // pin left low for a while must not start anything
    task automatic quiet(input logic [7:0] cv);
        wr(BBFO_ADDR_CTRL, cv);
        pin <= cv[5:1];
        fail <= 1'b1;
        repeat (20) @(negedge clock_i);
        `CHK(ctl_o.detach, 1'b0)
        @(posedge clock_i);
        fail <= 1'b0;
    endtask : quiet
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(BBFO_ADDR_CTRL, 8'h14);
        rd(BBFO_ADDR_STATUS, 8'h00);
        rd(16'h413c, 8'hd0);
        rd(16'h413d, 8'h07);
        rd(16'h413e, 8'hd0);
        rd(16'h413f, 8'h07);
        wr(16'h4142, 8'h5a);
        rd(16'h4142, 8'h00);
        wr(BBFO_ADDR_CTRL, 8'hfe);
        rd(BBFO_ADDR_CTRL, 8'h3e);
        wr(16'h413c, 8'h03);
        wr(16'h413d, 8'h00);
        wr(16'h413e, 8'ha5);
        wr(16'h413f, 8'h5a);
        rd(16'h413c, 8'h03);
        rd(16'h413d, 8'h00);
        rd(16'h413e, 8'ha5);
        rd(16'h413f, 8'h5a);
        quiet(8'h14);
        quiet(8'h13);
        for (k = 0; k <= 16; k++)
            if (k != 9)
                round(5'(k), 2 * T, 3 * T + 6);
        alt_en <= 1'b1;
        wr(16'h413c, 8'h64);
        wr(16'h413e, 8'h01);
        wr(16'h413f, 8'h00);
        round(5'h0a, 1, 2 * T);
        rd(BBFO_ADDR_STATUS, 8'h00);
        test_done();
    end
    // watchdog well past the expected run length
    initial begin
        repeat (30000) @(posedge clock_i);
        num_errors++;
        test_done();
    end
endmodule : test_billboard_failover_control
`default_nettype wire
